// ===== logic/probe_cfg_pkg.sv
// Package: holding register map, reset values and valid ranges of the probe
package probe_cfg_pkg;
    // Holding register addresses (16-bit register indexes)
    localparam logic [15:0] ADDR_TEMP_COMP = 16'h0505;
    localparam logic [15:0] ADDR_PURGE_MAN = 16'h0506;
    localparam logic [15:0] ADDR_PURGE_INT = 16'h0507;
    localparam logic [15:0] ADDR_NODE = 16'h0600;
    localparam logic [15:0] ADDR_BAUD = 16'h0601;
    localparam logic [15:0] ADDR_FRAME = 16'h0602;
    localparam logic [15:0] ADDR_DELAY = 16'h0603;
    localparam logic [15:0] ADDR_RESTART = 16'h0604;
    localparam logic [15:0] ADDR_OUT_MODE = 16'h0700;
    localparam logic [15:0] ADDR_OUT_PARAM = 16'h0701;
    localparam logic [15:0] ADDR_SCALE_LO = 16'h0702;
    localparam logic [15:0] ADDR_SCALE_HI = 16'h0704;
    localparam logic [15:0] ADDR_ERR_LVL = 16'h0706;
    // Reset values
    localparam logic [15:0] RST_TEMP_COMP = 16'h0001;
    localparam logic [15:0] RST_PURGE_MAN = 16'h0001;
    localparam logic [15:0] RST_PURGE_INT = 16'h0000;
    localparam logic [15:0] RST_NODE = 16'h00F0;
    localparam logic [15:0] RST_BAUD = 16'h0006;
    localparam logic [15:0] RST_FRAME = 16'h0001;
    localparam logic [15:0] RST_DELAY = 16'h0000;
    localparam logic [15:0] RST_OUT_MODE = 16'h0002;
    localparam logic [15:0] RST_OUT_PARAM = 16'h0000;
    localparam logic [31:0] RST_SCALE_LO = 32'h0000_0000;
    localparam logic [31:0] RST_SCALE_HI = 32'h42C8_0000;
    localparam logic [31:0] RST_ERR_LVL = 32'h4140_0000;
    // Valid ranges and codes
    localparam logic [15:0] NODE_MIN = 16'h0001;
    localparam logic [15:0] NODE_MAX = 16'h00FF;
    localparam logic [15:0] BAUD_MIN = 16'h0005;
    localparam logic [15:0] BAUD_MAX = 16'h0009;
    localparam logic [15:0] FRAME_MAX = 16'h0005;
    localparam logic [15:0] DELAY_MAX = 16'h03E8;
    localparam logic [15:0] PARAM_MAX = 16'h001A;
    localparam logic [15:0] MODE_OFF = 16'h0000;
    localparam logic [15:0] MODE_4_20 = 16'h0002;
    localparam logic [15:0] RESTART_CODE = 16'h0001;
    localparam logic [15:0] BOOL_MAX = 16'h0001;
endpackage

// ===== logic/probe_config_registers.sv
// Configuration holding-register bank of the probe with range checking
//
// Behaviour
// - Setpoint mode uses volatile and power-up setpoints.
// - Manual purge in analog mode enable, default on.
// - Node address 1 to 255, default 240.
// - Bit rate codes 5..9, default 6.
// - Framing codes 0..5 parity/stop, default 1.
// - Writing 1 to restart register restarts device.
// - Output mode 0 off, 2 current; default 2.
// - Float sets value at output scale low end.
// - Float sets value at output scale high end.
`timescale 1ns/1ps
module probe_config_registers (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] wr_data,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic rd_error,
    output logic wr_error,
    output logic use_setpoint_temp,
    output logic purge_man_enable,
    output logic purge_int_allow,
    output logic [7:0] node_addr,
    output logic [3:0] baud_code,
    output logic [1:0] parity_sel,
    output logic two_stop_bits,
    output logic [15:0] reply_delay,
    output logic restart_pulse,
    output logic out1_enable,
    output logic [15:0] out1_param,
    output logic [31:0] out1_scale_lo,
    output logic [31:0] out1_scale_hi,
    output logic [31:0] out1_err_level
);
    import probe_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset synchroniser
    logic rst_meta_q; // First stage, read only by the second
    logic rst_sync_q; // Released reset used by all logic

    // Two flops so release is clean against core_clk
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [15:0] temp_comp_source_q, temp_comp_source_d;
    logic [15:0] manual_purge_analog_enable_q, manual_purge_analog_enable_d;
    logic [15:0] interval_purge_during_exposure_q;
    logic [15:0] interval_purge_during_exposure_d;
    logic [15:0] node_address_q, node_address_d;
    logic [15:0] baud_select_q, baud_select_d;
    logic [15:0] frame_format_q, frame_format_d;
    logic [15:0] reply_delay_ms_q, reply_delay_ms_d;
    logic [15:0] out1_mode_q, out1_mode_d;
    logic [15:0] out1_parameter_select_q, out1_parameter_select_d;
    logic [31:0] out1_scale_low_q, out1_scale_low_d;
    logic [31:0] out1_scale_high_q, out1_scale_high_d;
    logic [31:0] out1_error_level_ma_q, out1_error_level_ma_d;
    logic [15:0] hold_hi_q, hold_hi_d;   // First half of a float pair
    logic [15:0] hold_addr_q, hold_addr_d; // Address of that first half
    logic hold_vld_q, hold_vld_d;        // First half captured
    logic [15:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;
    logic rd_error_q, rd_error_d;
    logic wr_error_q, wr_error_d;
    logic restart_q, restart_d;

    // Inclusive range test, used for the node address and bit rate fields
    function automatic logic in_range(input logic [15:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // Float pair decode: true only when addr is the base (first half) of a pair
    function automatic logic is_float(input logic [15:0] a);
        is_float = (a == ADDR_SCALE_LO) || (a == ADDR_SCALE_HI) ||
                   (a == ADDR_ERR_LVL);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: writes, float pairing, reads
    always_comb begin
        temp_comp_source_d = temp_comp_source_q;
        manual_purge_analog_enable_d = manual_purge_analog_enable_q;
        interval_purge_during_exposure_d = interval_purge_during_exposure_q;
        node_address_d = node_address_q;
        baud_select_d = baud_select_q;
        frame_format_d = frame_format_q;
        reply_delay_ms_d = reply_delay_ms_q;
        out1_mode_d = out1_mode_q;
        out1_parameter_select_d = out1_parameter_select_q;
        out1_scale_low_d = out1_scale_low_q;
        out1_scale_high_d = out1_scale_high_q;
        out1_error_level_ma_d = out1_error_level_ma_q;
        hold_hi_d = hold_hi_q;
        hold_addr_d = hold_addr_q;
        hold_vld_d = hold_vld_q;
        rd_data_d = 16'h0000;
        rd_valid_d = 1'b0;
        rd_error_d = 1'b0;
        wr_error_d = 1'b0;
        restart_d = 1'b0;
        if (wr_en) begin
            // Any write other than the pair's second half drops a half pair
            hold_vld_d = 1'b0;
            wr_error_d = 1'b1; // Cleared below when the write is accepted
            if (is_float(reg_addr)) begin
                // High word first; commit happens only on the low word
                hold_hi_d = wr_data;
                hold_addr_d = reg_addr;
                hold_vld_d = 1'b1;
                wr_error_d = 1'b0;
            end else if (hold_vld_q && (reg_addr == hold_addr_q + 16'h0001))
                begin
                // Second half completes the 32-bit value atomically
                wr_error_d = 1'b0;
                case (hold_addr_q)
                    ADDR_SCALE_LO: begin
                        out1_scale_low_d = {hold_hi_q, wr_data};
                    end
                    ADDR_SCALE_HI: begin
                        out1_scale_high_d = {hold_hi_q, wr_data};
                    end
                    default: out1_error_level_ma_d = {hold_hi_q, wr_data};
                endcase
            end else begin
                case (reg_addr)
                    ADDR_TEMP_COMP: if (wr_data <= BOOL_MAX) begin
                        temp_comp_source_d = wr_data;
                        wr_error_d = 1'b0;
                    end
                    ADDR_PURGE_MAN: if (wr_data <= BOOL_MAX) begin
                        manual_purge_analog_enable_d = wr_data;
                        wr_error_d = 1'b0;
                    end
                    ADDR_PURGE_INT: if (wr_data <= BOOL_MAX) begin
                        interval_purge_during_exposure_d = wr_data;
                        wr_error_d = 1'b0;
                    end
                    ADDR_NODE: if (in_range(wr_data, NODE_MIN, NODE_MAX)) begin
                        node_address_d = wr_data;
                        wr_error_d = 1'b0;
                    end
                    ADDR_BAUD: if (in_range(wr_data, BAUD_MIN, BAUD_MAX)) begin
                        baud_select_d = wr_data;
                        wr_error_d = 1'b0;
                    end
                    ADDR_FRAME: if (wr_data <= FRAME_MAX) begin
                        frame_format_d = wr_data;
                        wr_error_d = 1'b0;
                    end
                    ADDR_DELAY: if (wr_data <= DELAY_MAX) begin
                        reply_delay_ms_d = wr_data;
                        wr_error_d = 1'b0;
                    end
                    ADDR_RESTART: if (wr_data == RESTART_CODE) begin
                        restart_d = 1'b1;
                        wr_error_d = 1'b0;
                    end
                    ADDR_OUT_MODE: if ((wr_data == MODE_OFF) ||
                                       (wr_data == MODE_4_20)) begin
                        out1_mode_d = wr_data;
                        wr_error_d = 1'b0;
                    end
                    ADDR_OUT_PARAM: if (wr_data <= PARAM_MAX) begin
                        out1_parameter_select_d = wr_data;
                        wr_error_d = 1'b0;
                    end
                    default: wr_error_d = 1'b1; // Unmapped address
                endcase
            end
        end else if (rd_en) begin
            // Reads answer one cycle later; restart reads as zero
            rd_valid_d = 1'b1;
            case (reg_addr)
                ADDR_TEMP_COMP: rd_data_d = temp_comp_source_q;
                ADDR_PURGE_MAN: rd_data_d = manual_purge_analog_enable_q;
                ADDR_PURGE_INT: rd_data_d = interval_purge_during_exposure_q;
                ADDR_NODE: rd_data_d = node_address_q;
                ADDR_BAUD: rd_data_d = baud_select_q;
                ADDR_FRAME: rd_data_d = frame_format_q;
                ADDR_DELAY: rd_data_d = reply_delay_ms_q;
                ADDR_RESTART: rd_data_d = 16'h0000;
                ADDR_OUT_MODE: rd_data_d = out1_mode_q;
                ADDR_OUT_PARAM: rd_data_d = out1_parameter_select_q;
                ADDR_SCALE_LO: rd_data_d = out1_scale_low_q[31:16];
                ADDR_SCALE_LO + 16'h0001: rd_data_d = out1_scale_low_q[15:0];
                ADDR_SCALE_HI: rd_data_d = out1_scale_high_q[31:16];
                ADDR_SCALE_HI + 16'h0001: rd_data_d = out1_scale_high_q[15:0];
                ADDR_ERR_LVL: rd_data_d = out1_error_level_ma_q[31:16];
                ADDR_ERR_LVL + 16'h0001: begin
                    rd_data_d = out1_error_level_ma_q[15:0];
                end
                default: rd_error_d = 1'b1; // Unmapped reads as zero
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            temp_comp_source_q <= RST_TEMP_COMP;
            manual_purge_analog_enable_q <= RST_PURGE_MAN;
            interval_purge_during_exposure_q <= RST_PURGE_INT;
            node_address_q <= RST_NODE;
            baud_select_q <= RST_BAUD;
            frame_format_q <= RST_FRAME;
            reply_delay_ms_q <= RST_DELAY;
            out1_mode_q <= RST_OUT_MODE;
            out1_parameter_select_q <= RST_OUT_PARAM;
            out1_scale_low_q <= RST_SCALE_LO;
            out1_scale_high_q <= RST_SCALE_HI;
            out1_error_level_ma_q <= RST_ERR_LVL;
            hold_hi_q <= 16'h0000;
            hold_addr_q <= 16'h0000;
            hold_vld_q <= 1'b0;
            rd_data_q <= 16'h0000;
            rd_valid_q <= 1'b0;
            rd_error_q <= 1'b0;
            wr_error_q <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            temp_comp_source_q <= temp_comp_source_d;
            manual_purge_analog_enable_q <= manual_purge_analog_enable_d;
            interval_purge_during_exposure_q <=
                interval_purge_during_exposure_d;
            node_address_q <= node_address_d;
            baud_select_q <= baud_select_d;
            frame_format_q <= frame_format_d;
            reply_delay_ms_q <= reply_delay_ms_d;
            out1_mode_q <= out1_mode_d;
            out1_parameter_select_q <= out1_parameter_select_d;
            out1_scale_low_q <= out1_scale_low_d;
            out1_scale_high_q <= out1_scale_high_d;
            out1_error_level_ma_q <= out1_error_level_ma_d;
            hold_hi_q <= hold_hi_d;
            hold_addr_q <= hold_addr_d;
            hold_vld_q <= hold_vld_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            rd_error_q <= rd_error_d;
            wr_error_q <= wr_error_d;
            restart_q <= restart_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops; setpoint storage lives elsewhere
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign rd_error = rd_error_q;
    assign wr_error = wr_error_q;
    assign use_setpoint_temp = temp_comp_source_q[0];
    assign purge_man_enable = manual_purge_analog_enable_q[0];
    assign purge_int_allow = interval_purge_during_exposure_q[0];
    assign node_addr = node_address_q[7:0];
    assign baud_code = baud_select_q[3:0];
    assign parity_sel = frame_format_q[2:1]; // 0 none,1 even,2 odd
    assign two_stop_bits = frame_format_q[0];
    assign reply_delay = reply_delay_ms_q;
    assign restart_pulse = restart_q;
    // Only codes 0 and 2 are ever stored, so bit 1 alone marks current mode
    assign out1_enable = out1_mode_q[1];
    assign out1_param = out1_parameter_select_q;
    assign out1_scale_lo = out1_scale_low_q;
    assign out1_scale_hi = out1_scale_high_q;
    assign out1_err_level = out1_error_level_ma_q;
endmodule // probe_config_registers

// ===== tb/host_model.sv
// Host model issuing holding register reads and writes
`timescale 1ns/1ps
module host_model (
    input wire logic core_clk,
    input wire logic [15:0] rd_data,
    input wire logic rd_error,
    input wire logic wr_error,
    output logic wr_en,
    output logic rd_en,
    output logic [15:0] reg_addr,
    output logic [15:0] wr_data
);
    // Idle bus at time zero
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        reg_addr = 16'h0000;
        wr_data = 16'h0000;
    end
    // Single write; released lines show inverted values, not stale ones
    task automatic wr(input logic [15:0] a, d, output logic err);
        @(posedge core_clk) #1;
        {wr_en, reg_addr, wr_data} = {1'b1, a, d};
        @(posedge core_clk) #1;
        {wr_en, reg_addr, wr_data} = {1'b0, ~a, ~d};
        err = wr_error;
    endtask
    // Float pair sent whole: high word, then low word on the next edge
    task automatic wr2(input logic [15:0] a, hi, lo, output logic err);
        @(posedge core_clk) #1;
        {wr_en, reg_addr, wr_data} = {1'b1, a, hi};
        @(posedge core_clk) #1;
        {reg_addr, wr_data} = {a + 16'h0001, lo};
        @(posedge core_clk) #1;
        {wr_en, reg_addr, wr_data} = {1'b0, ~a, ~lo};
        err = wr_error;
    endtask
    // Single read; answer taken in the cycle rd_valid stands
    task automatic rd(input logic [15:0] a, output logic [15:0] d,
                      output logic err);
        @(posedge core_clk) #1;
        {rd_en, reg_addr} = {1'b1, a};
        @(posedge core_clk) #1;
        {rd_en, reg_addr} = {1'b0, ~a};
        d = rd_data;
        err = rd_error;
    endtask
endmodule // host_model

// ===== tb/probe_config_registers_properties.sv
// Concurrent checks on the probe register bank ports
`timescale 1ns/1ps
module probe_config_registers_properties
    import probe_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_error,
    input wire logic wr_error,
    input wire logic use_setpoint_temp,
    input wire logic [7:0] node_addr,
    input wire logic [3:0] baud_code,
    input wire logic [1:0] parity_sel,
    input wire logic restart_pulse,
    input wire logic out1_enable,
    input wire logic [31:0] out1_scale_lo
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////
    AST_RD_VALID: assert property (rd_en && !wr_en |=> rd_valid)
        else $error("read not answered");
    AST_RD_ERR: assert property (rd_error |-> rd_valid && !rd_data)
        else $error("read error without zero data");
    AST_TEMP: assert property (wr_en && reg_addr == ADDR_TEMP_COMP &&
        wr_data <= BOOL_MAX |=> use_setpoint_temp == $past(wr_data[0]))
        else $error("compensation source not taken");
    AST_NODE_BAD: assert property (wr_en && reg_addr == ADDR_NODE &&
        (wr_data < NODE_MIN || wr_data > NODE_MAX)
        |=> wr_error && $stable(node_addr))
        else $error("bad node address accepted");
    AST_BAUD: assert property (baud_code >= 4'h5 &&
        baud_code <= 4'h9)
        else $error("bit rate code out of range");
    AST_PARITY: assert property (parity_sel != 2'h3)
        else $error("parity code out of range");
    AST_RESTART: assert property (wr_en && reg_addr == ADDR_RESTART &&
        wr_data == RESTART_CODE |=> restart_pulse ##1 !restart_pulse)
        else $error("restart pulse missing or long");
    AST_RESTART_CAUSE: assert property (restart_pulse |->
        $past(wr_en && reg_addr == ADDR_RESTART && wr_data == RESTART_CODE))
        else $error("restart pulse without command");
    AST_MODE_OFF: assert property (wr_en &&
        reg_addr == ADDR_OUT_MODE && wr_data == MODE_OFF |=> !out1_enable)
        else $error("output not switched off");
    AST_PAIR: assert property (wr_en && reg_addr == ADDR_SCALE_LO ##1
        wr_en && reg_addr == ADDR_SCALE_LO + 16'h0001
        |=> out1_scale_lo == {$past(wr_data, 2), $past(wr_data)})
        else $error("scale low pair not committed");
    // Main scenarios reached
    COV_RESTART: cover property (restart_pulse);
    COV_RD_ERR: cover property (rd_error);
    COV_WR_ERR: cover property (wr_error);
endmodule // probe_config_registers_properties

// ===== tb/probe_config_registers_test.sv
// Self-checking testbench of the probe register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
    miscompares++; $display("mismatch %s expected %h seen %h", nm, ex, got); \
    end end
module probe_config_registers_test;
    import probe_cfg_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_en, rd_en, rd_valid, rd_error, wr_error, e;
    logic use_setpoint_temp, purge_man_enable, purge_int_allow;
    logic two_stop_bits, restart_pulse, out1_enable;
    logic [15:0] reg_addr, wr_data, rd_data, reply_delay, out1_param, d;
    logic [7:0] node_addr;
    logic [3:0] baud_code;
    logic [1:0] parity_sel;
    logic [31:0] out1_scale_lo, out1_scale_hi, out1_err_level;
    int miscompares = 0;
    int comparisons = 0;
    always #12.5 core_clk = ~core_clk;
    probe_config_registers u_probe_config_registers (
        .core_clk(core_clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
        .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_error(rd_error), .wr_error(wr_error),
        .use_setpoint_temp(use_setpoint_temp),
        .purge_man_enable(purge_man_enable),
        .purge_int_allow(purge_int_allow), .node_addr(node_addr),
        .baud_code(baud_code), .parity_sel(parity_sel),
        .two_stop_bits(two_stop_bits), .reply_delay(reply_delay),
        .restart_pulse(restart_pulse), .out1_enable(out1_enable),
        .out1_param(out1_param), .out1_scale_lo(out1_scale_lo),
        .out1_scale_hi(out1_scale_hi), .out1_err_level(out1_err_level));
    host_model u_host_model (.core_clk(core_clk), .rd_data(rd_data),
        .rd_error(rd_error), .wr_error(wr_error), .wr_en(wr_en),
        .rd_en(rd_en), .reg_addr(reg_addr), .wr_data(wr_data));
    ////////////////////////////////////////////////////////////////////
    task automatic w(input logic [15:0] a, v);
        u_host_model.wr(a, v, e);
    endtask
    task automatic r(input logic [15:0] a);
        u_host_model.rd(a, d, e);
    endtask
    // Power-up levels and readback of the node address and manual purge registers
    task automatic t_reset;
        `CHK("levels", 20'hDE0C7, {use_setpoint_temp, purge_man_enable,
            purge_int_allow, node_addr, baud_code, parity_sel,
            two_stop_bits, out1_enable, 1'b1})
        r(ADDR_NODE);
        `CHK("node rd", 16'h00F0, d)
        r(ADDR_PURGE_MAN);
        `CHK("purge rd", 16'h0001, d)
    endtask
    // Boundaries and every code of the bit rate and framing fields
    task automatic t_ranges;
        logic [2:0] f;
        w(ADDR_NODE, 16'h0000);
        `CHK("node 0 err", 1'b1, e)
        w(ADDR_NODE, 16'h0100);
        `CHK("node 256 err", 1'b1, e)
        w(ADDR_NODE, 16'h00FF);
        `CHK("node 255", 8'hFF, node_addr)
        for (int i = 4; i <= 10; i++) begin
            w(ADDR_BAUD, 16'(i));
            `CHK("baud err", (i < 5 || i > 9), e)
            `CHK("baud", 4'(i == 4 ? 6 : i == 10 ? 9 : i), baud_code)
        end
        for (int i = 0; i <= 6; i++) begin
            w(ADDR_FRAME, 16'(i));
            f = 3'(i == 6 ? 5 : i);
            `CHK("frame", f, {parity_sel, two_stop_bits})
        end
        w(ADDR_DELAY, 16'h03E8);
        w(ADDR_DELAY, 16'h03E9);
        `CHK("delay", 17'h103E8, {e, reply_delay})
    endtask
    // Restart: only code 1 fires, one cycle wide; reads as zero
    task automatic t_restart;
        w(ADDR_RESTART, 16'h0002);
        `CHK("bad restart", 2'b10, {e, restart_pulse})
        w(ADDR_RESTART, 16'h0001);
        `CHK("restart", 1'b1, restart_pulse)
        @(posedge core_clk) #1;
        `CHK("restart end", 1'b0, restart_pulse)
        r(ADDR_RESTART);
        `CHK("restart rd", 16'h0000, d)
    endtask
    // Output mode codes and compensation source
    task automatic t_mode;
        w(ADDR_OUT_MODE, 16'h0001);
        `CHK("mode 1", 2'b11, {e, out1_enable})
        w(ADDR_OUT_MODE, 16'h0000);
        `CHK("mode off", 1'b0, out1_enable)
        w(ADDR_TEMP_COMP, 16'h0000);
        `CHK("measured", 1'b0, use_setpoint_temp)
        w(ADDR_TEMP_COMP, 16'h0002);
        `CHK("comp bad", 2'b10, {e, use_setpoint_temp})
        w(ADDR_TEMP_COMP, 16'h0001);
        `CHK("setpoint", 1'b1, use_setpoint_temp)
        w(ADDR_PURGE_MAN, 16'h0000);
        `CHK("purge off", 1'b0, purge_man_enable)
        w(ADDR_PURGE_INT, 16'h0002);
        `CHK("purge int bad", 2'b10, {e, purge_int_allow})
        w(ADDR_OUT_PARAM, 16'h001A);
        w(ADDR_OUT_PARAM, 16'h001B);
        `CHK("param", 17'h1001A, {e, out1_param})
    endtask
    // Float pairs: whole, interrupted, orphaned and spaced
    task automatic t_float;
        u_host_model.wr2(ADDR_SCALE_LO, 16'h4120, 16'h0000, e);
        `CHK("scale lo", 32'h41200000, out1_scale_lo)
        r(ADDR_SCALE_LO);
        `CHK("lo hi word", 16'h4120, d)
        u_host_model.wr2(ADDR_SCALE_HI, 16'h447A, 16'h8000, e);
        `CHK("scale hi", 32'h447A8000, out1_scale_hi)
        w(ADDR_SCALE_HI, 16'h1111);
        w(ADDR_NODE, 16'h0005);
        w(ADDR_SCALE_HI + 16'h0001, 16'h2222);
        `CHK("orphan err", 1'b1, e)
        `CHK("hi kept", 32'h447A8000, out1_scale_hi)
        w(ADDR_ERR_LVL, 16'h41A0);
        w(ADDR_ERR_LVL + 16'h0001, 16'h0001);
        `CHK("err lvl", 32'h41A00001, out1_err_level)
        r(16'h0508);
        `CHK("unmapped rd", 17'h10000, {e, d})
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Reset held five cycles, then the scenarios in turn
    initial begin
        repeat (5) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_ranges();
        t_restart();
        t_mode();
        t_float();
        conclude();
    end
    // Watchdog well beyond the hundred or so cycles the scenarios need
    initial begin
        #100000;
        miscompares++;
        conclude();
    end
endmodule // probe_config_registers_test
bind probe_config_registers probe_config_registers_properties
    u_probe_config_registers_properties (
    .core_clk(core_clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
    .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_error(rd_error), .wr_error(wr_error),
    .use_setpoint_temp(use_setpoint_temp), .node_addr(node_addr),
    .baud_code(baud_code), .parity_sel(parity_sel),
    .restart_pulse(restart_pulse), .out1_enable(out1_enable),
    .out1_scale_lo(out1_scale_lo));
